// File: inc/cmd_decode_map.svh
`ifndef CMD_DECODE_MAP_SVH
`define CMD_DECODE_MAP_SVH

// Mode register select code for this register on BG/BA
`define MR_SEL_COLDLY_VREF   3'h6
// Field positions of the 22-bit register image
`define MR_CCDL_HI           12
`define MR_CCDL_LO           10
`define MR_VREF_EN_BIT       7
`define MR_VREF_RANGE_BIT    6
`define MR_VREF_VAL_HI       5
`define MR_VREF_VAL_LO       0
// Reset values
`define MR_RESET_VALUE       22'h000000
// Column-to-column delay base and largest legal code
`define CCDL_BASE_CLOCKS     4'h4
`define CCDL_MAX_CODE        3'h4
// Number of valid reference step codes per range
`define VREF_STEPS           6'h32

`endif

// File: inc/cmd_decode_pkg.sv
package cmd_decode_pkg;

    typedef enum logic [3:0] {
        CMD_NONE,
        CMD_MRS,
        CMD_REF,
        CMD_SRE,
        CMD_SRX,
        CMD_PRE,
        CMD_PREA,
        CMD_ACT,
        CMD_WR,
        CMD_RFU
    } cmd_t;

    typedef enum logic [1:0] {
        PWR_ACTIVE,
        PWR_SELF_REFRESH
    } pwr_t;

endpackage

// File: rtl/link_edge_sync.sv
`timescale 1ns/1ps

// Two-flop synchroniser for a pin group plus rising edge finder on bit 0
module link_edge_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_sync,
    output logic              rise
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic         last_q;

    // Two stages then edge history
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            meta_q <= '0;
            sync_q <= '0;
            last_q <= 1'b0;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
            last_q <= sync_q[0];
        end
    end

    assign pin_sync = sync_q;
    assign rise     = sync_q[0] & ~last_q;

endmodule

// File: rtl/cmd_decode.sv
`timescale 1ns/1ps
`include "cmd_decode_map.svh"

module cmd_decode (
    input  wire logic                 core_clk,
    input  wire logic                 rstn,
    input  wire logic                 ck_pin,
    input  wire logic                 cke_pin,
    input  wire logic                 cs_n_pin,
    input  wire logic                 act_n_pin,
    input  wire logic                 ras_n_a16_pin,
    input  wire logic                 cas_n_a15_pin,
    input  wire logic                 we_n_a14_pin,
    input  wire logic [1:0]           bg_pin,
    input  wire logic [1:0]           ba_pin,
    input  wire logic [13:0]          addr_pin,
    input  wire logic                 otf_burst_en,
    output logic                      cmd_valid,
    output cmd_decode_pkg::cmd_t      cmd_code,
    output logic [1:0]                cmd_bg,
    output logic [1:0]                cmd_ba,
    output logic [16:0]               cmd_row,
    output logic [9:0]                cmd_col,
    output logic                      cmd_auto_pre,
    output logic                      cmd_chop4,
    output logic                      self_refresh,
    output logic [21:0]               mr_image,
    output logic [3:0]                ccdl_clocks,
    output logic                      ccdl_code_bad,
    output logic                      vref_train_en,
    output logic                      vref_range2,
    output logic [5:0]                vref_step,
    output logic                      vref_step_bad,
    output logic                      ccdl_violation,
    output logic                      vref_probe_en
);
    import cmd_decode_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    localparam int PINS = 25;

    logic [PINS-1:0] pins_raw;
    logic [PINS-1:0] pins_s;
    logic            ck_rise;

    // Bit 0 is the link clock so its edges are found after sync
    assign pins_raw = {addr_pin, ba_pin, bg_pin, we_n_a14_pin, cas_n_a15_pin,
                       ras_n_a16_pin, act_n_pin, cs_n_pin, cke_pin, ck_pin};

    link_edge_sync #(
        .W (PINS)
    ) u_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .pin_in   (pins_raw),
        .pin_sync (pins_s),
        .rise     (ck_rise)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic        cke_prev;
        pwr_t        pwr;
        logic        cmd_valid;
        cmd_t        cmd_code;
        logic [1:0]  bg;
        logic [1:0]  ba;
        logic [16:0] row;
        logic [9:0]  col;
        logic        auto_pre;
        logic        chop4;
        logic [21:0] mr;
        logic [3:0]  ccdl_clk;
        logic        ccdl_bad;
        logic        step_bad;
        logic        probe;
        logic [3:0]  gap;
        logic [1:0]  last_bg;
        logic        col_seen;
        logic        viol;
    } state_t;

    state_t s_q;
    state_t s_d;

    // Code to clock count for the long column delay
    function automatic logic [3:0] ccdl_of(input logic [2:0] code);
        ccdl_of = `CCDL_BASE_CLOCKS + {1'b0, code};
    endfunction

    // Sampled pins at this link edge
    logic        cke;
    logic        cs_n;
    logic        act_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [1:0]  bg;
    logic [1:0]  ba;
    logic [13:0] a;
    logic [2:0]  mr_sel;
    logic [2:0]  cc;
    logic [3:0]  limit;

    assign cke   = pins_s[1];
    assign cs_n  = pins_s[2];
    assign act_n = pins_s[3];
    assign ras_n = pins_s[4];
    assign cas_n = pins_s[5];
    assign we_n  = pins_s[6];
    assign bg    = pins_s[8:7];
    assign ba    = pins_s[10:9];
    assign a     = pins_s[24:11];
    assign mr_sel = {bg[0], ba};
    assign cc    = a[`MR_CCDL_HI:`MR_CCDL_LO];
    // Device floor is four clocks, not five
    assign limit = `CCDL_BASE_CLOCKS;

    // ------------------------------------------------------------
    // Decode and state update
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.cmd_valid = 1'b0;
        // Column gap counter saturates at the link clock rate
        if (ck_rise && s_q.gap != 4'hf) begin
            s_d.gap = s_q.gap + 4'h1;
        end
        if (ck_rise) begin
            s_d.cke_prev = cke;
            if (!s_q.cke_prev && cke && s_q.pwr == PWR_SELF_REFRESH) begin
                if (cs_n || (act_n && ras_n && cas_n && we_n)) begin
                    s_d.pwr       = PWR_ACTIVE;
                    s_d.cmd_valid = 1'b1;
                    s_d.cmd_code  = CMD_SRX;
                end
            end else if (!cs_n && !act_n) begin
                s_d.cmd_valid = 1'b1;
                s_d.cmd_code  = CMD_ACT;
                s_d.bg        = bg;
                s_d.ba        = ba;
                s_d.row       = {ras_n, cas_n, we_n, a};
            end else if (!cs_n && s_q.cke_prev) begin
                s_d.cmd_valid = 1'b1;
                unique case ({ras_n, cas_n, we_n})
                    3'h0: begin
                        // register set, enable high in both cycles
                        s_d.cmd_valid = cke;
                        s_d.cmd_code = CMD_MRS;
                        s_d.bg       = bg;
                        s_d.ba       = ba;
                        if (cke && mr_sel == `MR_SEL_COLDLY_VREF) begin
                            s_d.mr = {bg, ba, 4'h0, a};
                            s_d.ccdl_clk = ccdl_of(cc);
                            s_d.ccdl_bad = (cc > `CCDL_MAX_CODE);
                            s_d.step_bad = (a[5:0] >= `VREF_STEPS);
                            s_d.probe    = a[`MR_VREF_EN_BIT];
                        end
                    end
                    3'h1: begin
                        s_d.cmd_code = cke ? CMD_REF : CMD_SRE;
                        if (!cke) begin
                            s_d.pwr = PWR_SELF_REFRESH;
                        end
                    end
                    3'h2: begin
                        s_d.cmd_code = a[10] ? CMD_PREA : CMD_PRE;
                        s_d.bg       = bg;
                        s_d.ba       = ba;
                    end
                    3'h4: begin
                        s_d.cmd_code = CMD_WR;
                        s_d.bg       = bg;
                        s_d.ba       = ba;
                        s_d.col      = a[9:0];
                        s_d.auto_pre = a[10];
                        s_d.chop4    = otf_burst_en && !a[12];
                        s_d.viol     = s_q.col_seen && s_q.last_bg == bg
                                       && s_q.gap < limit;
                        s_d.gap      = 4'h1;
                        s_d.last_bg  = bg;
                        s_d.col_seen = 1'b1;
                    end
                    default: begin
                        // reserved and others: no state change
                        s_d.cmd_valid = 1'b0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            s_q <= '0;
            s_q.mr       <= `MR_RESET_VALUE;
            s_q.ccdl_clk <= `CCDL_BASE_CLOCKS;
            s_q.gap      <= 4'hf;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign cmd_valid      = s_q.cmd_valid;
    assign cmd_code       = s_q.cmd_code;
    assign cmd_bg         = s_q.bg;
    assign cmd_ba         = s_q.ba;
    assign cmd_row        = s_q.row;
    assign cmd_col        = s_q.col;
    assign cmd_auto_pre   = s_q.auto_pre;
    assign cmd_chop4      = s_q.chop4;
    assign self_refresh   = (s_q.pwr == PWR_SELF_REFRESH);
    assign mr_image       = s_q.mr;
    assign ccdl_clocks    = s_q.ccdl_clk;
    assign ccdl_code_bad  = s_q.ccdl_bad;
    assign vref_train_en  = s_q.mr[`MR_VREF_EN_BIT];
    assign vref_range2    = s_q.mr[`MR_VREF_RANGE_BIT];
    assign vref_step      = s_q.mr[`MR_VREF_VAL_HI:`MR_VREF_VAL_LO];
    assign vref_step_bad  = s_q.step_bad;
    assign ccdl_violation = s_q.viol;
    assign vref_probe_en  = s_q.probe;

endmodule

// File: bench/cmd_decode_sva.sv
`timescale 1ns/1ps

// -------------------------------------------------
// Checker on the decoder's ports
// -------------------------------------------------
module cmd_decode_sva (
    input wire logic                 core_clk,
    input wire logic                 rstn,
    input wire logic                 ck_pin,
    input wire logic                 cmd_valid,
    input wire cmd_decode_pkg::cmd_t cmd_code,
    input wire logic [21:0]          mr_image,
    input wire logic [3:0]           ccdl_clocks,
    input wire logic                 ccdl_code_bad,
    input wire logic                 vref_train_en,
    input wire logic                 vref_range2,
    input wire logic [5:0]           vref_step,
    input wire logic                 vref_step_bad,
    input wire logic                 self_refresh
);
    import cmd_decode_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // Decode steps
    sequence pulse_s;
        $rose(cmd_valid);
    endsequence
    sequence mrs_s;
        cmd_valid && cmd_code == CMD_MRS;
    endsequence
    pulse_one_a: assert property (pulse_s |=> !cmd_valid)
        else $error("command pulse longer than one cycle");
    valid_ck_a: assert property (cmd_valid |-> ck_pin && $past(ck_pin))
        else $error("command seen without link clock edge");
    no_rfu_a: assert property (cmd_valid |-> cmd_code != CMD_RFU && cmd_code != CMD_NONE)
        else $error("reserved encoding reported");
    ccdl_map_a: assert property (ccdl_clocks == 4'h4 + {1'b0, mr_image[12:10]})
        else $error("delay clocks wrong");
    ccdl_bad_a: assert property (ccdl_code_bad == (mr_image[12:10] > 3'h4))
        else $error("delay code flag wrong");
    vref_map_a: assert property ({vref_train_en, vref_range2, vref_step} == mr_image[7:0])
        else $error("training fields wrong");
    step_bad_a: assert property (vref_step_bad == (vref_step >= 6'h32))
        else $error("step flag wrong");
    mr_write_a: assert property ($changed(mr_image) |-> mrs_s)
        else $error("register image changed without register set");
    sr_exit_a: assert property ($fell(self_refresh) |-> cmd_code == CMD_SRX)
        else $error("self refresh left without exit");
endmodule

bind cmd_decode cmd_decode_sva cmd_decode_sva_inst (
    .core_clk(core_clk), .rstn(rstn), .ck_pin(ck_pin), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .mr_image(mr_image), .ccdl_clocks(ccdl_clocks),
    .ccdl_code_bad(ccdl_code_bad), .vref_train_en(vref_train_en),
    .vref_range2(vref_range2), .vref_step(vref_step), .vref_step_bad(vref_step_bad),
    .self_refresh(self_refresh)
);

// File: bench/ctrl_model.sv
`timescale 1ns/1ps

// Controller: ctl is {cke, cs_n, act_n, ras_n, cas_n, we_n}
module ctrl_model (
    input  wire logic   core_clk,
    output logic        ck_pin,
    output logic [5:0]  ctl,
    output logic [1:0]  bg,
    output logic [1:0]  ba,
    output logic [13:0] addr
);
    initial begin
        ck_pin = 1'b0;
        ctl    = 6'h3f;
        bg     = 2'h0;
        ba     = 2'h0;
        addr   = 14'h0;
    end
    // Pins settle before the link clock rises
    task automatic issue(input logic [5:0] c, input logic [1:0] g, input logic [1:0] b,
                         input logic [13:0] a);
        ctl    <= c;
        bg     <= g;
        ba     <= b;
        addr   <= a;
        repeat (3) @(posedge core_clk);
        ck_pin <= 1'b1;
        repeat (8) @(posedge core_clk);
        ck_pin <= 1'b0;
        ctl    <= {c[5], 1'b1, ~c[3:0]}; // Hold over: deselect, stale pins inverted
        bg     <= ~g;
        ba     <= ~b;
        addr   <= ~a;
        repeat (5) @(posedge core_clk);
    endtask
endmodule

// File: bench/cmd_decode_test.sv
`timescale 1ns/1ps

module cmd_decode_test;
    import cmd_decode_pkg::*;
    logic core_clk, rstn, otf, ck_pin;
    logic [5:0] ctl;
    logic [1:0] bg, ba, cmd_bg, cmd_ba;
    logic [13:0] addr;
    logic cmd_valid, cmd_auto_pre, cmd_chop4, self_refresh, ccdl_code_bad, vref_train_en;
    logic vref_range2, vref_step_bad, ccdl_violation, vref_probe_en;
    cmd_t cmd_code;
    logic [16:0] cmd_row;
    logic [9:0] cmd_col;
    logic [21:0] mr_image, exp_mr;
    logic [3:0] ccdl_clocks;
    logic [5:0] vref_step;
    logic [31:0] r, a;
    int seed, miscompares, cmp_count, n_valid, ck_n, last_wr, i;

    ctrl_model ctrl_model_inst (.core_clk(core_clk), .ck_pin(ck_pin), .ctl(ctl), .bg(bg),
        .ba(ba), .addr(addr));
    cmd_decode cmd_decode_inst (.core_clk(core_clk), .rstn(rstn), .ck_pin(ck_pin),
        .cke_pin(ctl[5]), .cs_n_pin(ctl[4]), .act_n_pin(ctl[3]), .ras_n_a16_pin(ctl[2]),
        .cas_n_a15_pin(ctl[1]), .we_n_a14_pin(ctl[0]), .bg_pin(bg), .ba_pin(ba),
        .addr_pin(addr), .otf_burst_en(otf), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_bg(cmd_bg), .cmd_ba(cmd_ba), .cmd_row(cmd_row), .cmd_col(cmd_col),
        .cmd_auto_pre(cmd_auto_pre), .cmd_chop4(cmd_chop4), .self_refresh(self_refresh),
        .mr_image(mr_image), .ccdl_clocks(ccdl_clocks), .ccdl_code_bad(ccdl_code_bad),
        .vref_train_en(vref_train_en), .vref_range2(vref_range2), .vref_step(vref_step),
        .vref_step_bad(vref_step_bad), .ccdl_violation(ccdl_violation),
        .vref_probe_en(vref_probe_en));

    // Clock and pulse counter
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) if (cmd_valid === 1'b1) n_valid <= n_valid + 1;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic run(input logic [5:0] c, input logic [1:0] g, input logic [1:0] b,
                       input logic [13:0] aa, input int nv);
        int v0;
        v0 = n_valid;
        ctrl_model_inst.issue(c, g, b, aa);
        ck_n++;
        chk(n_valid - v0, nv);
    endtask
    task automatic wrap_up;
        $display("compares %0d miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        wrap_up;
    end

    // Main sequence
    initial begin
        {rstn, otf, miscompares, cmp_count, n_valid, ck_n} = '0;
        seed = 32'h29f5;
        last_wr = -100;
        exp_mr = 22'h0;
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk(ccdl_clocks, 4);
        // Deselect edge primes the held clock enable history
        run(6'h3f, 2'h0, 2'h0, 14'h0, 0);
        // Training enable set, reserved bits zero, every delay code
        for (i = 0; i < 8; i++) begin
            r = $random(seed);
            a = {19'h0, i[2:0], 3'h1, r[6:0]};
            exp_mr = {4'h6, 4'h0, a[13:0]};
            run(6'h28, 2'h1, 2'h2, a[13:0], 1);
            chk(mr_image, exp_mr);
            chk(ccdl_clocks, 4 + i);
            chk(ccdl_code_bad, i > 4);
            chk(vref_range2, a[6]);
            chk({vref_step_bad, vref_step}, {a[5:0] >= 50, a[5:0]});
            chk({vref_train_en, vref_probe_en}, 2'h3);
        end
        // Training steps the value up by one, then back down
        for (i = 0; i < 3; i++) begin
            a = {19'h0, 3'h0, 3'h1, 1'b0, 6'h18 + {5'h0, i[0]}};
            exp_mr = {4'h6, 4'h0, a[13:0]};
            run(6'h28, 2'h1, 2'h2, a[13:0], 1);
            chk({vref_range2, vref_step}, a[6:0]);
        end
        run(6'h28, 2'h1, 2'h1, 14'h3fff, 1);
        chk(mr_image, exp_mr);
        // Activate with random row on shared pins
        for (i = 0; i < 4; i++) begin
            r = $random(seed);
            run({3'h4, r[16:14]}, r[18:17], r[20:19], r[13:0], 1);
            chk({cmd_code, cmd_bg, cmd_ba, cmd_row}, {CMD_ACT, r[18:17], r[20:19], r[16:0]});
        end
        // Writes spaced one to four link clocks apart
        for (i = 0; i < 8; i++) begin
            r = $random(seed);
            a = {18'h0, r[13], i[1], r[11], i[0], r[9:0]};
            otf <= i[2];
            repeat (i % 4) run(6'h3f, 2'h0, 2'h0, 14'h0, 0);
            run(6'h2c, 2'h2, 2'h1, a[13:0], 1);
            chk(ccdl_violation, ck_n - last_wr < 4);
            last_wr = ck_n;
            chk({cmd_code, cmd_col, cmd_auto_pre}, {CMD_WR, a[9:0], i[0]});
            chk(cmd_chop4, i[2] & ~i[1]);
        end
        for (i = 0; i < 2; i++) begin
            run(6'h2a, 2'h1, 2'h2, {3'h0, i[0], 10'h0}, 1);
            chk(cmd_code, i[0] ? CMD_PREA : CMD_PRE);
        end
        run(6'h2b, 2'h0, 2'h0, 14'h1555, 0);
        chk({cmd_code, mr_image}, {CMD_PREA, exp_mr});
        run(6'h29, 2'h0, 2'h0, 14'h0, 1);
        chk(cmd_code, CMD_REF);
        run(6'h09, 2'h0, 2'h0, 14'h0, 1);
        chk({cmd_code, self_refresh}, {CMD_SRE, 1'b1});
        run(6'h3f, 2'h0, 2'h0, 14'h0, 1);
        chk({cmd_code, self_refresh}, {CMD_SRX, 1'b0});
        wrap_up;
    end
endmodule
